// file: core/tpdp_clk_div.sv
`timescale 1ns/1ps
module tpdp_clk_div #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] half_i,
  output logic              clk_o
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_nx;

  // ---------------------------------------------------------------
  // toggle divider
  // ---------------------------------------------------------------
  assign cnt_nx = cnt_q + W'(1);

  // toggle after half_i cycles, zero treated as one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      clk_o <= 1'b0;
    end else if (ce_i) begin
      if (cnt_nx >= half_i) begin
        cnt_q <= '0;
        clk_o <= ~clk_o;
      end else begin
        cnt_q <= cnt_nx;
      end
    end
  end

endmodule

// file: core/tpdp_pkg.sv
package tpdp_pkg;

  // ---------------------------------------------------------------
  // clock and sizes
  // ---------------------------------------------------------------
  localparam int SYS_CLK_HZ = 40_000_000;
  localparam int PIN_COUNT  = 8;
  localparam int SEL_W      = 3;
  localparam int DIV_W      = 8;
  localparam int CLK_COUNT  = 4;

  // ---------------------------------------------------------------
  // debug clock frequencies
  // ---------------------------------------------------------------
  localparam int CLK_FAST_HZ    = 60_000_000;
  localparam int CLK_HALF_HZ    = 30_000_000;
  localparam int CLK_SLOW_HZ    = 7_500_000;
  localparam int CLK_VAR_MIN_HZ = 700_000;
  localparam int CLK_VAR_MAX_HZ = 22_500_000;

  // half period in system cycles, rounded down, never below one
  function automatic int half_cycles(input int hz);
    int h;
    h = SYS_CLK_HZ / (2 * hz);
    return (h < 1) ? 1 : h;
  endfunction

  localparam logic [DIV_W-1:0] HALF_FAST    = DIV_W'(half_cycles(CLK_FAST_HZ));
  localparam logic [DIV_W-1:0] HALF_HALF    = DIV_W'(half_cycles(CLK_HALF_HZ));
  localparam logic [DIV_W-1:0] HALF_SLOW    = DIV_W'(half_cycles(CLK_SLOW_HZ));
  localparam logic [DIV_W-1:0] HALF_VAR_LO  =
    DIV_W'(half_cycles(CLK_VAR_MAX_HZ));
  localparam logic [DIV_W-1:0] HALF_VAR_HI  =
    DIV_W'(half_cycles(CLK_VAR_MIN_HZ));

  // ---------------------------------------------------------------
  // strap codes and reset values
  // ---------------------------------------------------------------
  localparam logic [SEL_W-1:0]     SEL_IDLE   = 3'h0;
  localparam logic [SEL_W-1:0]     SEL_CLKDBG = 3'h2;
  localparam logic [PIN_COUNT-1:0] STRAP_RST  = 8'h00;
  localparam logic [PIN_COUNT-1:0] PULL_ALL   = 8'hff;
  localparam logic [PIN_COUNT-1:0] DRIVE_NONE = 8'h00;

  // what a test point drives
  typedef enum logic [2:0] {
    SRC_HIZ      = 3'b000,
    SRC_LOW      = 3'b001,
    SRC_HIGH     = 3'b010,
    SRC_CLK_FAST = 3'b011,
    SRC_CLK_HALF = 3'b100,
    SRC_CLK_VAR  = 3'b101,
    SRC_CLK_SLOW = 3'b110
  } tpdp_src_type;

endpackage

// file: core/tpdp_top.sv
//
// Overview of operation
// - All eight test points are inputs in reset; after release only pins with a non high impedance source are outputs.
// - Pin levels captured at release set test mode until next reset.
// - Every test point has a weak pulldown; unstrapped pins capture zero.
// - Straps latch only on reset release; later changes do nothing.
// - Captured code 000 keeps every test point in high impedance.
// - Test mode comes only from the three low strap bits.
// - Code 010 drives 20,20,var MHz, high, low, high, high, 10 MHz.
// - Strap outputs are defaults; software may reselect any pin later.
`timescale 1ns/1ps
module tpdp_top (
  input  wire logic       SYS_CLK_I,
  input  wire logic       RST_I,
  input  wire logic       CE_I,
  input  wire logic [7:0] DEBUG_STRAP_PINS_I,
  output logic      [7:0] DEBUG_STRAP_PINS_O,
  output logic      [7:0] DEBUG_STRAP_PINS_OE_O,
  output logic      [7:0] DEBUG_STRAP_PULLDOWN_EN_O,
  input  wire logic       SW_SEL_WE_I,
  input  wire logic [2:0] SW_SEL_PIN_I,
  input  wire logic [2:0] SW_SEL_SRC_I,
  input  wire logic [7:0] VAR_CLK_HALF_I,
  output logic      [7:0] STRAP_CFG_O,
  output logic      [2:0] TEST_MODE_O
);

  localparam int NP = tpdp_pkg::PIN_COUNT;
  localparam int DW = tpdp_pkg::DIV_W;
  localparam int NC = tpdp_pkg::CLK_COUNT;

  logic [NP-1:0]          sync1_q;
  logic [NP-1:0]          sync2_q;
  logic [NP-1:0]          sync3_q;
  logic [NP-1:0]          stable_q;
  logic                   rst_q;
  logic                   release_w;
  tpdp_pkg::tpdp_src_type src_q [NP];
  tpdp_pkg::tpdp_src_type sw_src_w;
  logic [DW-1:0]          var_half_w;
  logic [DW-1:0]          clk_half_w [NC];
  logic [NC-1:0]          dbg_clk_w;

  // ---------------------------------------------------------------
  // default pin sources per strap code
  // ---------------------------------------------------------------
  function automatic tpdp_pkg::tpdp_src_type default_src(
    input logic [2:0] sel,
    input int         pin
  );
    tpdp_pkg::tpdp_src_type s;
    s = tpdp_pkg::SRC_HIZ;
    if (sel == tpdp_pkg::SEL_CLKDBG) begin
      case (pin)
        0:       s = tpdp_pkg::SRC_CLK_FAST;
        1:       s = tpdp_pkg::SRC_CLK_HALF;
        2:       s = tpdp_pkg::SRC_CLK_VAR;
        3:       s = tpdp_pkg::SRC_HIGH;
        4:       s = tpdp_pkg::SRC_LOW;
        5:       s = tpdp_pkg::SRC_HIGH;
        6:       s = tpdp_pkg::SRC_HIGH;
        7:       s = tpdp_pkg::SRC_CLK_SLOW;
        default: s = tpdp_pkg::SRC_HIZ;
      endcase
    end
    return s;
  endfunction

  // ---------------------------------------------------------------
  // strap pin synchroniser
  // ---------------------------------------------------------------
  // three stages, free running so straps are seen during reset
  always_ff @(posedge SYS_CLK_I) begin
    if (CE_I) begin
      sync1_q <= DEBUG_STRAP_PINS_I;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // accept a level once stages two and three agree per bit
  always_ff @(posedge SYS_CLK_I) begin
    if (CE_I) begin
      for (int i = 0; i < NP; i++) begin
        if (sync2_q[i] == sync3_q[i]) begin
          stable_q[i] <= sync3_q[i];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // reset release detect
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      rst_q <= 1'b1;
    end else if (CE_I) begin
      rst_q <= 1'b0;
    end
  end

  assign release_w = rst_q & ~RST_I & CE_I;

  // ---------------------------------------------------------------
  // captured configuration
  // ---------------------------------------------------------------
  // latched once per release, held until reset asserts again
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      STRAP_CFG_O <= tpdp_pkg::STRAP_RST;
      TEST_MODE_O <= tpdp_pkg::SEL_IDLE;
    end else if (release_w) begin
      STRAP_CFG_O <= stable_q;
      TEST_MODE_O <= stable_q[2:0];
    end
  end

  // internal weak pulldown on every test point
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      DEBUG_STRAP_PULLDOWN_EN_O <= tpdp_pkg::PULL_ALL;
    end
  end

  // ---------------------------------------------------------------
  // per pin source selection
  // ---------------------------------------------------------------
  // codes above the enum range read as high impedance
  always_comb begin
    if (SW_SEL_SRC_I > 3'(tpdp_pkg::SRC_CLK_SLOW)) begin
      sw_src_w = tpdp_pkg::SRC_HIZ;
    end else begin
      sw_src_w = tpdp_pkg::tpdp_src_type'(SW_SEL_SRC_I);
    end
  end

  // defaults at release, software reselect afterwards
  always_ff @(posedge SYS_CLK_I) begin
    for (int p = 0; p < NP; p++) begin
      if (RST_I) begin
        src_q[p] <= tpdp_pkg::SRC_HIZ;
      end else if (release_w) begin
        src_q[p] <= default_src(stable_q[2:0], p);
      end else if (CE_I && SW_SEL_WE_I && (int'(SW_SEL_PIN_I) == p)) begin
        src_q[p] <= sw_src_w;
      end
    end
  end

  // ---------------------------------------------------------------
  // debug clock generation
  // ---------------------------------------------------------------
  // variable clock clamped into its documented band
  always_comb begin
    if (VAR_CLK_HALF_I < tpdp_pkg::HALF_VAR_LO) begin
      var_half_w = tpdp_pkg::HALF_VAR_LO;
    end else if (VAR_CLK_HALF_I > tpdp_pkg::HALF_VAR_HI) begin
      var_half_w = tpdp_pkg::HALF_VAR_HI;
    end else begin
      var_half_w = VAR_CLK_HALF_I;
    end
  end

  assign clk_half_w[0] = tpdp_pkg::HALF_FAST;
  assign clk_half_w[1] = tpdp_pkg::HALF_HALF;
  assign clk_half_w[2] = var_half_w;
  assign clk_half_w[3] = tpdp_pkg::HALF_SLOW;

  // one divider per debug clock
  for (genvar g = 0; g < NC; g++) begin : g_div
    tpdp_clk_div #(
      .W (DW)
    ) u_div (
      .clk_i  (SYS_CLK_I),
      .rst_i  (RST_I),
      .ce_i   (CE_I),
      .half_i (clk_half_w[g]),
      .clk_o  (dbg_clk_w[g])
    );
  end

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  // inputs only during reset, outputs per source afterwards
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      DEBUG_STRAP_PINS_O    <= tpdp_pkg::DRIVE_NONE;
      DEBUG_STRAP_PINS_OE_O <= tpdp_pkg::DRIVE_NONE;
    end else if (CE_I) begin
      for (int p = 0; p < NP; p++) begin
        DEBUG_STRAP_PINS_OE_O[p] <= 1'b1;
        case (src_q[p])
          tpdp_pkg::SRC_LOW:      DEBUG_STRAP_PINS_O[p] <= 1'b0;
          tpdp_pkg::SRC_HIGH:     DEBUG_STRAP_PINS_O[p] <= 1'b1;
          tpdp_pkg::SRC_CLK_FAST: DEBUG_STRAP_PINS_O[p] <= dbg_clk_w[0];
          tpdp_pkg::SRC_CLK_HALF: DEBUG_STRAP_PINS_O[p] <= dbg_clk_w[1];
          tpdp_pkg::SRC_CLK_VAR:  DEBUG_STRAP_PINS_O[p] <= dbg_clk_w[2];
          tpdp_pkg::SRC_CLK_SLOW: DEBUG_STRAP_PINS_O[p] <= dbg_clk_w[3];
          default: begin
            DEBUG_STRAP_PINS_O[p]    <= 1'b0;
            DEBUG_STRAP_PINS_OE_O[p] <= 1'b0;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_release_cfg(logic [2:0] code);
    release_w && (stable_q[2:0] == code) ##1 CE_I && !RST_I;
  endsequence

  sequence s_sw_high;
    CE_I && !RST_I && !release_w && SW_SEL_WE_I &&
      (SW_SEL_SRC_I == 3'(tpdp_pkg::SRC_HIGH)) ##1 CE_I && !RST_I;
  endsequence

  property p_in_reset_inputs;
    @(posedge SYS_CLK_I) RST_I |=> (DEBUG_STRAP_PINS_OE_O == 8'h00);
  endproperty
  a_in_reset_inputs: assert property (p_in_reset_inputs)
    else $error("test points driven during reset");

  property p_cfg_held;
    @(posedge SYS_CLK_I) disable iff (RST_I)
      !$past(RST_I) && !$past(release_w) |-> $stable(STRAP_CFG_O);
  endproperty
  a_cfg_held: assert property (p_cfg_held)
    else $error("captured configuration changed without reset");

  // one edge after any reset cycle the pulldowns must be on
  property p_pulldown_on;
    @(posedge SYS_CLK_I)
      RST_I |=> (DEBUG_STRAP_PULLDOWN_EN_O == 8'hff);
  endproperty
  a_pulldown_on: assert property (p_pulldown_on)
    else $error("pulldown not enabled");

  property p_capture_release;
    @(posedge SYS_CLK_I) disable iff (RST_I)
      release_w |=> (STRAP_CFG_O == $past(stable_q));
  endproperty
  a_capture_release: assert property (p_capture_release)
    else $error("strap value not captured at release");

  property p_idle_hiz;
    @(posedge SYS_CLK_I) disable iff (RST_I)
      s_release_cfg(3'h0) |=> (DEBUG_STRAP_PINS_OE_O == 8'h00);
  endproperty
  a_idle_hiz: assert property (p_idle_hiz)
    else $error("idle code drives a test point");

  property p_mode_low_bits;
    @(posedge SYS_CLK_I) disable iff (RST_I)
      $past(release_w) |-> (TEST_MODE_O == STRAP_CFG_O[2:0]);
  endproperty
  a_mode_low_bits: assert property (p_mode_low_bits)
    else $error("test mode not from low strap bits");

  property p_clkdbg_levels;
    @(posedge SYS_CLK_I) disable iff (RST_I)
      s_release_cfg(3'h2) ##0 !SW_SEL_WE_I |=>
        (DEBUG_STRAP_PINS_OE_O == 8'hff) &&
        (DEBUG_STRAP_PINS_O[6:3] == 4'hd);
  endproperty
  a_clkdbg_levels: assert property (p_clkdbg_levels)
    else $error("clock debug fixed levels wrong");

  // pin index taken from the write edge, two edges before the check
  property p_sw_reselect;
    @(posedge SYS_CLK_I) disable iff (RST_I)
      s_sw_high |=>
        DEBUG_STRAP_PINS_O[$past(SW_SEL_PIN_I, 2)] &&
        DEBUG_STRAP_PINS_OE_O[$past(SW_SEL_PIN_I, 2)];
  endproperty
  a_sw_reselect: assert property (p_sw_reselect)
    else $error("software reselect not applied");

  property p_other_hiz;
    @(posedge SYS_CLK_I) disable iff (RST_I)
      release_w && (stable_q[2:0] != 3'h0) && (stable_q[2:0] != 3'h2)
        ##1 CE_I && !SW_SEL_WE_I ##1 CE_I && !SW_SEL_WE_I |=>
        (DEBUG_STRAP_PINS_OE_O == 8'h00);
  endproperty
  a_other_hiz: assert property (p_other_hiz)
    else $error("undocumented code drives a test point");

endmodule

// file: verification/tpdp_board_model.sv
`timescale 1ns/1ps
module tpdp_board_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] pin_o_i,
  input  wire logic [7:0] pin_oe_i,
  input  wire logic [7:0] pull_dn_i,
  input  wire logic [7:0] pull_up_i,
  output logic      [7:0] pin_lvl_o
);
  logic [7:0] last_q = 8'h00;

  // ---------------------------------------------------------------
  // pin resolution
  // ---------------------------------------------------------------
  // driver first, then board pullup, then weak pulldown, else drifting
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe_i[i]) begin
        pin_lvl_o[i] = pin_o_i[i];
      end else if (pull_up_i[i]) begin
        pin_lvl_o[i] = 1'b1;
      end else if (pull_dn_i[i]) begin
        pin_lvl_o[i] = 1'b0;
      end else begin
        pin_lvl_o[i] = ~last_q[i];
      end
    end
  end

  // last level, so a floating pin never repeats it
  always_ff @(posedge clk_i) begin
    last_q <= pin_lvl_o;
  end
endmodule

// file: verification/tpdp_top_test.sv
`timescale 1ns/1ps
module tpdp_top_test;
  logic       clk      = 1'b0;
  logic       rst      = 1'b1;
  logic       ce       = 1'b1;
  logic       we       = 1'b0;
  logic [2:0] sw_pin   = 3'h0;
  logic [2:0] sw_src   = 3'h0;
  logic [7:0] var_half = 8'h04;
  logic [7:0] pull_up  = 8'h00;
  logic [7:0] pin_in;
  logic [7:0] pin_o;
  logic [7:0] pin_oe;
  logic [7:0] pd_en;
  logic [7:0] cfg;
  logic [2:0] mode;
  int         n_mismatch = 0;
  int         n_checks   = 0;

  // ---------------------------------------------------------------
  // design and board
  // ---------------------------------------------------------------
  tpdp_top i_dut (
    .SYS_CLK_I                 (clk),
    .RST_I                     (rst),
    .CE_I                      (ce),
    .DEBUG_STRAP_PINS_I        (pin_in),
    .DEBUG_STRAP_PINS_O        (pin_o),
    .DEBUG_STRAP_PINS_OE_O     (pin_oe),
    .DEBUG_STRAP_PULLDOWN_EN_O (pd_en),
    .SW_SEL_WE_I               (we),
    .SW_SEL_PIN_I              (sw_pin),
    .SW_SEL_SRC_I              (sw_src),
    .VAR_CLK_HALF_I            (var_half),
    .STRAP_CFG_O               (cfg),
    .TEST_MODE_O               (mode)
  );

  tpdp_board_model i_board (
    .clk_i     (clk),
    .pin_o_i   (pin_o),
    .pin_oe_i  (pin_oe),
    .pull_dn_i (pd_en),
    .pull_up_i (pull_up),
    .pin_lvl_o (pin_in)
  );

  // ---------------------------------------------------------------
  // clock, watchdog, helpers
  // ---------------------------------------------------------------
  initial begin
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // clamped half period of the variable clock
  function automatic int exp_half(input logic [7:0] h);
    return (h < 1) ? 1 : ((h > 28) ? 28 : int'(h));
  endfunction

  // default enables for a captured code
  function automatic logic [7:0] exp_oe(input logic [2:0] c);
    return (c == tpdp_pkg::SEL_CLKDBG) ? 8'hff : 8'h00;
  endfunction

  // enable in bit 1, level in bit 0, per reselect source
  function automatic logic [7:0] exp_sw(input logic [2:0] s);
    return (s == 3'h0 || s == 3'h7) ? 8'h00 : ((s == 3'h1) ? 8'h02 : 8'h03);
  endfunction

  // count toggles of one output over n cycles
  task automatic count_tog(input int b, input int n, output int t);
    logic prev;
    prev = pin_o[b];
    t = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (pin_o[b] !== prev) t++;
      prev = pin_o[b];
    end
  endtask

  // reset with straps, a stray write inside, then release
  task automatic do_reset(input logic [7:0] strap);
    @(posedge clk);
    rst     <= 1'b1;
    pull_up <= strap;
    repeat (2) @(posedge clk);
    we     <= 1'b1;
    sw_pin <= 3'h4;
    sw_src <= 3'h2;
    @(posedge clk);
    we <= 1'b0;
    tick(3);
    chk(pin_oe, 8'h00);
    chk(pd_en, 8'hff);
    @(posedge clk);
    rst <= 1'b0;
    tick(3);
  endtask

  task automatic sw_write(input logic [2:0] p, input logic [2:0] s);
    logic [7:0] m;
    m = (s == 3'h1 || s == 3'h2) ? 8'h03 : 8'h02;
    @(posedge clk);
    we     <= 1'b1;
    sw_pin <= p;
    sw_src <= s;
    @(posedge clk);
    we <= 1'b0;
    tick(2);
    chk({6'h00, pin_oe[p], pin_o[p]} & m, exp_sw(s) & m);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] strap;
    logic [2:0] code;
    int         t;
    void'($urandom(32'hd41785f3));
    for (int k = 0; k < 24; k++) begin
      code  = k[2:0];
      strap = {(k < 8) ? 5'h00 : 5'($urandom), code};
      @(posedge clk);
      var_half <= 8'($urandom % 32);
      do_reset(strap);
      chk(cfg, strap);
      chk({5'h00, mode}, {5'h00, strap[2:0]});
      chk(pin_oe, exp_oe(code));
      if (code == tpdp_pkg::SEL_CLKDBG) begin
        chk(pin_o & 8'h78, 8'h68);
        count_tog(0, int'(tpdp_pkg::HALF_FAST) * 8, t);
        chk(8'(t), 8'h08);
        count_tog(1, int'(tpdp_pkg::HALF_HALF) * 8, t);
        chk(8'(t), 8'h08);
        count_tog(7, int'(tpdp_pkg::HALF_SLOW) * 8, t);
        chk(8'(t), 8'h08);
        count_tog(2, exp_half(var_half) * 8, t);
        chk(8'(t), 8'h08);
      end
      @(posedge clk);
      pull_up <= ~strap;
      tick(5);
      chk(cfg, strap);
      chk(pin_oe, exp_oe(code));
      repeat (4) sw_write(3'($urandom), 3'($urandom));
    end
    // a write while the clock enable is low is dropped
    sw_write(3'h0, 3'h0);
    @(posedge clk);
    ce     <= 1'b0;
    we     <= 1'b1;
    sw_src <= 3'h2;
    @(posedge clk);
    we <= 1'b0;
    ce <= 1'b1;
    tick(3);
    chk({7'h00, pin_oe[0]}, 8'h00);
    wrap_up();
  end
endmodule
